// ---- design/tsp_pkg.sv ----
// Purpose: Shared constants for the temperature sensor serial slave port.
// Assumes: Imported whole by tsp_slave_port; tsp_sync does not use it.
// Notes:   Threshold and configuration layouts match the register map.
package tsp_pkg;

  // Slave address: fixed upper nibble, straps fill bits 3..1
  localparam logic [3:0]  TSP_ADDR_FIXED    = 4'h9;

  // Pointer values
  localparam logic [1:0]  TSP_PTR_TEMP      = 2'h0;
  localparam logic [1:0]  TSP_PTR_CONF      = 2'h1;
  localparam logic [1:0]  TSP_PTR_HYS       = 2'h2;
  localparam logic [1:0]  TSP_PTR_OS        = 2'h3;

  // Power-up defaults
  localparam logic [1:0]  TSP_PTR_RESET     = 2'h0;
  localparam logic [7:0]  TSP_CONF_RESET    = 8'h00;
  localparam logic [15:0] TSP_HYS_RESET     = 16'h4b00;
  localparam logic [15:0] TSP_OS_RESET      = 16'h5000;
  localparam logic [15:0] TSP_TEMP_RESET    = 16'h0000;

  // Configuration field positions
  localparam int          TSP_CONF_SD       = 0;
  localparam int          TSP_CONF_MODE     = 1;
  localparam int          TSP_CONF_POL      = 2;
  localparam int          TSP_CONF_FT_LO    = 3;
  localparam int          TSP_CONF_FT_HI    = 4;
  localparam int          TSP_CONF_RC_LO    = 5;
  localparam int          TSP_CONF_RC_HI    = 6;

  // Masks: conf bit 7 reads zero, threshold low nibble hardwired zero
  localparam logic [7:0]  TSP_CONF_WR_MASK  = 8'h7f;
  localparam logic [7:0]  TSP_THR_LSB_MASK  = 8'hf0;

  // Byte framing
  localparam logic [3:0]  TSP_BITS_PER_BYTE = 4'h8;
  localparam logic [7:0]  TSP_IDLE_BYTE     = 8'hff;
  localparam logic [1:0]  TSP_IDX_MAX       = 2'h3;

  // Link engine states
  typedef enum logic [2:0] {
    TSP_IDLE,
    TSP_ADDR,
    TSP_ADDR_ACK,
    TSP_WR,
    TSP_WR_ACK,
    TSP_RD,
    TSP_RD_ACK,
    TSP_RD_NEXT
  } tsp_state_type;

endpackage

// ---- design/tsp_sync.sv ----
// Purpose: Two-flop level synchroniser.
// Assumes: Input is a level, stable long enough to be seen.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module tsp_sync (
  // Destination clock
  input  wire logic clk,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  // No reset, so it can also carry a reset into a new domain
  always_ff @(posedge clk) begin
    meta_reg <= async_in;
    sync_out <= meta_reg;
  end

endmodule
`default_nettype wire

// ---- design/tsp_slave_port.sv ----
// Purpose: Two-wire serial slave port with pointer, configuration and trip points.
// Assumes: Link logic runs on link_clk, which oversamples scl_in and sda_in.
// Notes:   Registers live in the link domain; copies cross to clk by toggle
//          handshakes, and the temperature word crosses the other way.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Power-up: comparator mode, active-low polarity, one fault; those bits zero.
// - Power-up pointer is 00, selecting the temperature register.
// - Power-up resolution is 9-bit; both resolution bits zero.
// - All defaults stay writable through the serial port afterwards.
// - Transfers run in nine-clock groups: eight data bits then acknowledge.
// - Answer address 1001 plus three strap bits; last bit is direction.
// - A transfer begins only while both lines are high.
// - Data changes with clock low; change with clock high is a condition.
// - Data falling while clock high is START.
// - Data rising while clock high is STOP.
// - Unlimited bytes per transfer; receiver acknowledges every byte.
// - Acknowledger holds data low across the whole acknowledge high phase.
// - Addressed device acknowledges every byte received from the master.
// - Master not-acknowledges last read byte; slave then releases data high.
// - After matching write address, first received byte loads the pointer.
// - Pointer 00 temp, 01 config, 10 hysteresis, 11 over-limit.
// - Over-limit resets to 80 degrees, hysteresis to 75 degrees.
module tsp_slave_port
  import tsp_pkg::*;
(
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Link oversampling clock
  input  wire logic        link_clk,
  // Serial pins (open drain data)
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Address straps
  input  wire logic        addr_strap_hi,
  input  wire logic        addr_strap_mid,
  input  wire logic        addr_strap_lo,
  // Measured temperature from the core
  input  wire logic [15:0] temp_value,
  // Configuration and trip points to the core
  output logic             shutdown,
  output logic             thermostat_mode,
  output logic             alarm_polarity,
  output logic [1:0]       fault_tolerance,
  output logic             res_sel_hi,
  output logic             res_sel_lo,
  output logic [15:0]      hysteresis_threshold,
  output logic [15:0]      over_limit_threshold
);

  // Byte returned for a pointer and byte index
  function automatic logic [7:0] read_byte(input logic [1:0]  ptr,
                                           input logic [1:0]  idx,
                                           input logic [15:0] temp,
                                           input logic [7:0]  conf,
                                           input logic [15:0] hys,
                                           input logic [15:0] os);
    logic [15:0] word;
    word = temp;
    case (ptr)
      TSP_PTR_CONF: word = {conf, TSP_IDLE_BYTE};
      TSP_PTR_HYS:  word = hys;
      TSP_PTR_OS:   word = os;
      default:      word = temp;
    endcase
    if (idx == 2'h0) begin
      read_byte = word[15:8];
    end else if (idx == 2'h1) begin
      read_byte = word[7:0];
    end else begin
      read_byte = TSP_IDLE_BYTE;
    end
  endfunction

  // ---------------- Link domain ----------------
  logic          link_rst;
  logic          scl_s;
  logic          sda_s;
  logic          strap_hi_s;
  logic          strap_mid_s;
  logic          strap_lo_s;
  logic          scl_d;
  logic          sda_d;
  tsp_state_type state_reg;
  logic [3:0]    cnt_reg;
  logic [7:0]    shift_reg;
  logic [7:0]    tx_reg;
  logic [1:0]    idx_reg;
  logic          rw_reg;
  logic [1:0]    ptr_reg;
  logic [7:0]    conf_reg;
  logic [15:0]   hys_reg;
  logic [15:0]   os_reg;
  logic [15:0]   temp_reg;
  logic [7:0]    next_byte;

  // Synchronise reset, pins and straps into the link domain
  tsp_sync u_sync_rst (.clk(link_clk), .async_in(rst),            .sync_out(link_rst));
  tsp_sync u_sync_scl (.clk(link_clk), .async_in(scl_in),         .sync_out(scl_s));
  tsp_sync u_sync_sda (.clk(link_clk), .async_in(sda_in),         .sync_out(sda_s));
  tsp_sync u_sync_hi  (.clk(link_clk), .async_in(addr_strap_hi),  .sync_out(strap_hi_s));
  tsp_sync u_sync_mid (.clk(link_clk), .async_in(addr_strap_mid), .sync_out(strap_mid_s));
  tsp_sync u_sync_lo  (.clk(link_clk), .async_in(addr_strap_lo),  .sync_out(strap_lo_s));

  // Previous line levels for edge detection
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Line events; data moving while clock high is a condition
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic addr_hit;
  logic wr_commit;
  logic reading;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign addr_hit   = shift_reg[7:1] == {TSP_ADDR_FIXED, strap_hi_s, strap_mid_s, strap_lo_s};
  assign wr_commit  = (state_reg == TSP_WR) && scl_fall && (cnt_reg == TSP_BITS_PER_BYTE)
                      && !start_cond && !stop_cond;
  // Frozen from the read address ack on, so MSB and LSB come from one sample
  assign reading    = (state_reg == TSP_RD) || (state_reg == TSP_RD_ACK) || (state_reg == TSP_RD_NEXT)
                      || (state_reg == TSP_ADDR_ACK && rw_reg);
  assign next_byte  = read_byte(ptr_reg, idx_reg, temp_reg, conf_reg, hys_reg, os_reg);

  // Protocol engine; changes its data drive only while the clock is low
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg <= TSP_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      idx_reg   <= 2'h0;
      rw_reg    <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= TSP_IDLE;
      sda_oe    <= 1'b0;
    end else if (start_cond) begin
      state_reg <= TSP_ADDR;
      cnt_reg   <= 4'h0;
      idx_reg   <= 2'h0;
      sda_oe    <= 1'b0;
    end else begin
      case (state_reg)
        TSP_ADDR, TSP_WR: begin
          if (scl_rise && cnt_reg != TSP_BITS_PER_BYTE) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            cnt_reg   <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == TSP_BITS_PER_BYTE) begin
            if (state_reg == TSP_WR) begin
              sda_oe    <= 1'b1;
              state_reg <= TSP_WR_ACK;
            end else if (addr_hit) begin
              sda_oe    <= 1'b1;
              rw_reg    <= shift_reg[0];
              state_reg <= TSP_ADDR_ACK;
            end else begin
              state_reg <= TSP_IDLE;
            end
          end
        end
        TSP_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              tx_reg    <= {next_byte[6:0], 1'b1};
              sda_oe    <= ~next_byte[7];
              cnt_reg   <= 4'h1;
              state_reg <= TSP_RD;
            end else begin
              sda_oe    <= 1'b0;
              cnt_reg   <= 4'h0;
              state_reg <= TSP_WR;
            end
          end
        end
        TSP_WR_ACK: begin
          if (scl_fall) begin
            sda_oe    <= 1'b0;
            cnt_reg   <= 4'h0;
            idx_reg   <= (idx_reg == TSP_IDX_MAX) ? idx_reg : idx_reg + 2'h1;
            state_reg <= TSP_WR;
          end
        end
        TSP_RD: begin
          if (scl_fall) begin
            if (cnt_reg == TSP_BITS_PER_BYTE) begin
              sda_oe    <= 1'b0;
              state_reg <= TSP_RD_ACK;
            end else begin
              sda_oe    <= ~tx_reg[7];
              tx_reg    <= {tx_reg[6:0], 1'b1};
              cnt_reg   <= cnt_reg + 4'h1;
            end
          end
        end
        TSP_RD_ACK: begin
          if (scl_rise) begin
            if (!sda_s) begin
              idx_reg   <= (idx_reg == TSP_IDX_MAX) ? idx_reg : idx_reg + 2'h1;
              state_reg <= TSP_RD_NEXT;
            end else begin
              state_reg <= TSP_IDLE;
            end
          end
        end
        TSP_RD_NEXT: begin
          if (scl_fall) begin
            tx_reg    <= {next_byte[6:0], 1'b1};
            sda_oe    <= ~next_byte[7];
            cnt_reg   <= 4'h1;
            state_reg <= TSP_RD;
          end
        end
        default: begin
          state_reg <= TSP_IDLE;
          sda_oe    <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: only ever drives low
  always_ff @(posedge link_clk) begin
    sda_out <= 1'b0;
  end

  // Register file writes; defaults at reset, replaced by later writes
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ptr_reg  <= TSP_PTR_RESET;
      conf_reg <= TSP_CONF_RESET;
      hys_reg  <= TSP_HYS_RESET;
      os_reg   <= TSP_OS_RESET;
    end else if (wr_commit) begin
      if (idx_reg == 2'h0) begin
        ptr_reg <= shift_reg[1:0];
      end else if (ptr_reg == TSP_PTR_CONF && idx_reg == 2'h1) begin
        conf_reg <= shift_reg & TSP_CONF_WR_MASK;
      end else if (ptr_reg == TSP_PTR_HYS) begin
        if (idx_reg == 2'h1) begin
          hys_reg[15:8] <= shift_reg;
        end else if (idx_reg == 2'h2) begin
          hys_reg[7:0] <= shift_reg & TSP_THR_LSB_MASK;
        end
      end else if (ptr_reg == TSP_PTR_OS) begin
        if (idx_reg == 2'h1) begin
          os_reg[15:8] <= shift_reg;
        end else if (idx_reg == 2'h2) begin
          os_reg[7:0] <= shift_reg & TSP_THR_LSB_MASK;
        end
      end
    end
  end

  // ---------------- Crossing: settings to clk ----------------
  logic        cfg_req_reg;
  logic        cfg_ack_s;
  logic        cfg_dirty_reg;
  logic [39:0] cfg_hold_reg;
  logic        cfg_launch;
  assign cfg_launch = cfg_dirty_reg && (cfg_req_reg == cfg_ack_s);

  // Snapshot held stable until the clk side acknowledges
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cfg_req_reg   <= 1'b0;
      cfg_dirty_reg <= 1'b0;
      cfg_hold_reg  <= {TSP_CONF_RESET, TSP_HYS_RESET, TSP_OS_RESET};
    end else begin
      // A commit in the launch cycle keeps dirty set
      cfg_dirty_reg <= wr_commit | (cfg_dirty_reg & ~cfg_launch);
      if (cfg_launch) begin
        cfg_hold_reg <= {conf_reg, hys_reg, os_reg};
        cfg_req_reg  <= ~cfg_req_reg;
      end
    end
  end

  logic cfg_req_s;
  logic cfg_ack_reg;
  tsp_sync u_sync_cfg_req (.clk(clk),      .async_in(cfg_req_reg), .sync_out(cfg_req_s));
  tsp_sync u_sync_cfg_ack (.clk(link_clk), .async_in(cfg_ack_reg), .sync_out(cfg_ack_s));

  // Core-side copies of the settings
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_ack_reg          <= 1'b0;
      shutdown             <= TSP_CONF_RESET[TSP_CONF_SD];
      thermostat_mode      <= TSP_CONF_RESET[TSP_CONF_MODE];
      alarm_polarity       <= TSP_CONF_RESET[TSP_CONF_POL];
      fault_tolerance      <= TSP_CONF_RESET[TSP_CONF_FT_HI:TSP_CONF_FT_LO];
      res_sel_hi           <= TSP_CONF_RESET[TSP_CONF_RC_HI];
      res_sel_lo           <= TSP_CONF_RESET[TSP_CONF_RC_LO];
      hysteresis_threshold <= TSP_HYS_RESET;
      over_limit_threshold <= TSP_OS_RESET;
    end else if (cfg_req_s != cfg_ack_reg) begin
      cfg_ack_reg          <= cfg_req_s;
      shutdown             <= cfg_hold_reg[32 + TSP_CONF_SD];
      thermostat_mode      <= cfg_hold_reg[32 + TSP_CONF_MODE];
      alarm_polarity       <= cfg_hold_reg[32 + TSP_CONF_POL];
      fault_tolerance      <= cfg_hold_reg[32 + TSP_CONF_FT_HI:32 + TSP_CONF_FT_LO];
      res_sel_hi           <= cfg_hold_reg[32 + TSP_CONF_RC_HI];
      res_sel_lo           <= cfg_hold_reg[32 + TSP_CONF_RC_LO];
      hysteresis_threshold <= cfg_hold_reg[31:16];
      over_limit_threshold <= cfg_hold_reg[15:0];
    end
  end

  // ---------------- Crossing: temperature to link ----------------
  logic        tmp_req_reg;
  logic        tmp_ack_s;
  logic [15:0] tmp_hold_reg;

  // Capture a fresh sample only when the previous one was taken
  always_ff @(posedge clk) begin
    if (rst) begin
      tmp_req_reg  <= 1'b0;
      tmp_hold_reg <= TSP_TEMP_RESET;
    end else if (tmp_req_reg == tmp_ack_s) begin
      tmp_hold_reg <= temp_value;
      tmp_req_reg  <= ~tmp_req_reg;
    end
  end

  logic tmp_req_s;
  logic tmp_ack_reg;
  tsp_sync u_sync_tmp_req (.clk(link_clk), .async_in(tmp_req_reg), .sync_out(tmp_req_s));
  tsp_sync u_sync_tmp_ack (.clk(clk),      .async_in(tmp_ack_reg), .sync_out(tmp_ack_s));

  // Hold off updates during a read so both bytes belong together
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      tmp_ack_reg <= 1'b0;
      temp_reg    <= TSP_TEMP_RESET;
    end else if (tmp_req_s != tmp_ack_reg && !reading) begin
      temp_reg    <= tmp_hold_reg;
      tmp_ack_reg <= tmp_req_s;
    end
  end

endmodule
`default_nettype wire

// ---- tb/tsp_asserts.sv ----
// Purpose: Port checker for the serial slave port.
// Assumes: Master moves its lines on link_clk falling edges.
// Notes:   A small byte tracker watches the raw wires.
`timescale 1ns/1ps
`default_nettype none
module tsp_asserts (
  // Clocks and reset
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        link_clk,
  // Serial pins
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  // Straps
  input wire logic        addr_strap_hi,
  input wire logic        addr_strap_mid,
  input wire logic        addr_strap_lo,
  // Settings
  input wire logic        shutdown,
  input wire logic        thermostat_mode,
  input wire logic        alarm_polarity,
  input wire logic [1:0]  fault_tolerance,
  input wire logic        res_sel_hi,
  input wire logic        res_sel_lo,
  input wire logic [15:0] hysteresis_threshold,
  input wire logic [15:0] over_limit_threshold
);
  logic       scl_q, sda_q, scl_c, first, rw, rel;
  logic [3:0] bitc;
  logic [7:0] sh;
  logic [8:0] quiet;
  wire logic  rise  = scl_in && !scl_q;
  wire logic  begun = scl_in && scl_q && sda_q && !sda_in;
  wire logic  ended = scl_in && scl_q && !sda_q && sda_in;
  wire logic  match = sh[7:1] == {4'h9, addr_strap_hi, addr_strap_mid, addr_strap_lo};
  wire logic [7:0] cfg = {1'b0, res_sel_hi, res_sel_lo, fault_tolerance, alarm_polarity, thermostat_mode, shutdown};
  // Raw line history for condition detection
  always_ff @(posedge link_clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
  end
  // Byte position; released after mismatch, NACK or STOP
  always_ff @(posedge link_clk) begin
    if (rst || ended) begin
      rel  <= 1'b1;
      bitc <= 4'h0;
    end else if (begun) begin
      rel   <= 1'b0;
      first <= 1'b1;
      bitc  <= 4'h0;
    end else if (rise && bitc == 4'h8) begin
      bitc  <= 4'h0;
      first <= 1'b0;
      if (first) rw <= sh[0];
      if ((first && !match) || (!first && rw && sda_in)) rel <= 1'b1;
    end else if (rise) begin
      sh   <= {sh[6:0], sda_in};
      bitc <= bitc + 4'h1;
    end
  end
  // Quiet time on scl; settings must not drift when nothing is written
  always_ff @(posedge clk) begin
    scl_c <= scl_in;
    if (rst || scl_in != scl_c) quiet <= 9'h000;
    else if (quiet != 9'h1ff) quiet <= quiet + 9'h001;
  end
  a_pin_low: assert property (@(posedge link_clk) disable iff (rst) !sda_out)
    else $error("data pin driven high");
  a_reset_vals: assert property (@(posedge clk) rst |=> cfg == 8'h00 && hysteresis_threshold == 16'h4b00 &&
    over_limit_threshold == 16'h5000) else $error("reset values wrong");
  a_thr_nibble: assert property (@(posedge clk) disable iff (rst)
    hysteresis_threshold[3:0] == 4'h0 && over_limit_threshold[3:0] == 4'h0) else $error("threshold nibble set");
  a_cfg_quiet: assert property (@(posedge clk) disable iff (rst) quiet == 9'h1ff |->
    $stable({cfg, hysteresis_threshold, over_limit_threshold})) else $error("settings moved while idle");
  a_oe_steady: assert property (@(posedge link_clk) disable iff (rst) scl_in && scl_q |-> $stable(sda_oe))
    else $error("data changed with clock high");
  a_addr_ack: assert property (@(posedge link_clk) disable iff (rst)
    rise && first && bitc == 4'h8 |-> sda_oe == match) else $error("address ack wrong");
  a_wr_ack: assert property (@(posedge link_clk) disable iff (rst)
    rise && !first && !rw && !rel && bitc == 4'h8 |-> sda_oe) else $error("written byte not acked");
  a_bus_free: assert property (@(posedge link_clk) disable iff (rst) rel && !begun |-> !sda_oe)
    else $error("data held after release");
  c_match: cover property (@(posedge link_clk) rise && first && bitc == 4'h8 && match);
  c_nack: cover property (@(posedge link_clk) rise && !first && rw && bitc == 4'h8 && sda_in);
  c_write: cover property (@(posedge clk) $changed(over_limit_threshold));
endmodule
bind tsp_slave_port tsp_asserts i_tsp_asserts (.clk, .rst, .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe,
  .addr_strap_hi, .addr_strap_mid, .addr_strap_lo, .shutdown, .thermostat_mode, .alarm_polarity,
  .fault_tolerance, .res_sel_hi, .res_sel_lo, .hysteresis_threshold, .over_limit_threshold);
`default_nettype wire

// ---- tb/tsp_i2c_master.sv ----
// Purpose: Behavioural two-wire bus master.
// Assumes: Data wire is pulled up; this model only pulls it low.
// Notes:   Clock stands high between frames; bit high phases are PH link clocks, low phases PH+1.
`timescale 1ns/1ps
`default_nettype none
module tsp_i2c_master #(parameter int PH = 5) (
  // Link timing and resolved data wire
  input wire logic link_clk,
  input wire logic sda,
  // Driven lines
  output logic     scl,
  output logic     sda_pull
);
  // Idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge link_clk);
  endtask
  // Master alone starts frames and makes the clock
  task automatic start();
    sda_pull = 1'b0;
    wt(PH);
    scl = 1'b1;
    wt(PH);
    sda_pull = 1'b1;
    wt(PH);
    scl = 1'b0;
    wt(1);
  endtask
  // Data moves only with the clock low; sampled mid high phase
  task automatic xfer_bit(input logic b, output logic r);
    sda_pull = ~b;
    wt(PH);
    scl = 1'b1;
    wt(PH / 2);
    r = sda;
    wt(PH - PH / 2);
    scl = 1'b0;
    wt(1);
  endtask
  // Eight bits MSB first, then the ninth, with no gaps
  task automatic xfer_byte(input logic [7:0] d, input logic ninth, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], q[i]);
    xfer_bit(ninth, ack);
  endtask
  // Data rises with clock high to end the frame
  task automatic stop();
    sda_pull = 1'b1;
    wt(PH);
    scl = 1'b1;
    wt(PH);
    sda_pull = 1'b0;
    wt(PH);
  endtask
endmodule
`default_nettype wire

// ---- tb/test_temp_sensor_serial_slave_port.sv ----
// Purpose: Self-checking bench for the serial slave port.
// Assumes: Master model on a 125 ns link clock, 200 MHz system clock.
// Notes:   Settings are polled under a bound after reset, the configuration write and both trip-point writes.
`timescale 1ns/1ps
`default_nettype none
module test_temp_sensor_serial_slave_port;
  logic        clk, rst, link_clk, scl_in, sda_pull, sda_out, sda_oe;
  logic        addr_strap_hi, addr_strap_mid, addr_strap_lo;
  logic        shutdown, thermostat_mode, alarm_polarity, res_sel_hi, res_sel_lo;
  logic [1:0]  fault_tolerance;
  logic [15:0] temp_value, hysteresis_threshold, over_limit_threshold, v;
  logic [7:0]  q8;
  logic [6:0]  dev;
  int          bad_count, check_count;
  // Pulled-up wire, low when anyone pulls
  wire logic   sda_in = ~(sda_oe | sda_pull);
  wire logic [15:0] cfg = {9'h000, res_sel_hi, res_sel_lo, fault_tolerance, alarm_polarity, thermostat_mode, shutdown};
  // Clocks; link clock offset so edges never coincide
  always #2.5 clk = ~clk;
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #62.5 link_clk = ~link_clk;
  end
  tsp_slave_port i_tsp_slave_port (.clk, .rst, .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_strap_hi,
    .addr_strap_mid, .addr_strap_lo, .temp_value, .shutdown, .thermostat_mode, .alarm_polarity,
    .fault_tolerance, .res_sel_hi, .res_sel_lo, .hysteresis_threshold, .over_limit_threshold);
  tsp_i2c_master i_tsp_i2c_master (.link_clk, .sda(sda_in), .scl(scl_in), .sda_pull);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One byte either way; the ninth bit seen on the wire is compared
  task automatic txb(input logic [7:0] d, input logic ninth, input logic exp_ack, output logic [7:0] q);
    logic a;
    i_tsp_i2c_master.xfer_byte(d, ninth, q, a);
    check({15'h0000, a}, {15'h0000, exp_ack});
  endtask
  // Pointer then up to two data bytes; no STOP lets a read follow
  task automatic wr(input logic [7:0] ptr, input logic [15:0] val, input int n, input logic fin);
    logic [7:0] q;
    i_tsp_i2c_master.start();
    txb({dev, 1'b0}, 1'b1, 1'b0, q);
    txb(ptr, 1'b1, 1'b0, q);
    for (int k = 0; k < n; k++) txb(val[15 - 8 * k -: 8], 1'b1, 1'b0, q);
    if (fin) i_tsp_i2c_master.stop();
  endtask
  // Read n bytes, NACK on the last
  task automatic rd(input int n, output logic [15:0] got);
    logic [7:0] q;
    got = 16'h0000;
    i_tsp_i2c_master.start();
    txb({dev, 1'b1}, 1'b1, 1'b0, q);
    for (int k = 0; k < n; k++) begin
      txb(8'hff, k == n - 1, k == n - 1, q);
      got = {got[7:0], q};
    end
    i_tsp_i2c_master.stop();
  endtask
  // Settings cross clock domains, so poll under a bound
  task automatic settle(input logic [15:0] c, input logic [15:0] h, input logic [15:0] o);
    int i;
    for (i = 0; i < 1000 && !(cfg === c && hysteresis_threshold === h && over_limit_threshold === o); i++)
      @(negedge clk);
    check(cfg, c);
    check(hysteresis_threshold, h);
    check(over_limit_threshold, o);
    if (i == 1000) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr_strap_hi = 1'b0;
    addr_strap_mid = 1'b0;
    addr_strap_lo = 1'b0;
    temp_value = 16'h1a80;
    dev = 7'h48;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(negedge clk);
    repeat (4) @(posedge link_clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (5) @(posedge link_clk);
    settle(16'h0000, 16'h4b00, 16'h5000);
    $display("test reset defaults done");
    rd(2, v);
    check(v, 16'h1a80);
    $display("test default pointer read done");
    wr(8'h01, 16'hff00, 1, 1'b1);
    settle(16'h007f, 16'h4b00, 16'h5000);
    rd(1, v);
    check(v, 16'h007f);
    $display("test configuration done");
    wr(8'h03, 16'h55ab, 2, 1'b1);
    wr(8'h02, 16'hf12f, 2, 1'b1);
    settle(16'h007f, 16'hf120, 16'h55a0);
    wr(8'h03, 16'h0000, 0, 1'b0);
    rd(2, v);
    check(v, 16'h55a0);
    $display("test trip points done");
    @(negedge clk);
    addr_strap_hi = 1'b1;
    addr_strap_mid = 1'b1;
    addr_strap_lo = 1'b1;
    repeat (4) @(posedge link_clk);
    i_tsp_i2c_master.start();
    txb(8'h9c, 1'b1, 1'b1, q8);
    txb(8'h02, 1'b1, 1'b1, q8);
    i_tsp_i2c_master.stop();
    dev = 7'h4f;
    rd(2, v);
    check(v, 16'h55a0);
    $display("test address straps done");
    wr(8'h02, 16'h0000, 0, 1'b0);
    rd(2, v);
    check(v, 16'hf120);
    $display("test hysteresis readback done");
    wrap_up();
  end
endmodule
`default_nettype wire
